// >>> simb_bus_timer.sv
`timescale 1ns/1ps
`default_nettype none
module simb_bus_timer (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // processor bus cycle
    input wire logic cycle_active,
    input wire logic cycle_done,
    // result
    output logic timeout_pulse,
    output logic [7:0] count
);
    logic [7:0] cnt_q;
    logic fired_q;
    logic pulse_q;

    assign count = cnt_q;
    assign timeout_pulse = pulse_q;

    // counts cycles of an open bus cycle, fires once at the limit
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= simb_pkg::CNT_ZERO;
            fired_q <= 1'b0;
            pulse_q <= 1'b0;
        end else if (!cycle_active || cycle_done) begin
            cnt_q <= simb_pkg::CNT_ZERO;
            fired_q <= 1'b0;
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= 1'b0;
            if (!fired_q) begin
                if (cnt_q == simb_pkg::BUS_TIMEOUT_CNT - 8'h01) begin
                    pulse_q <= 1'b1;
                    fired_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
        end
    end

    a_timer_fires: assert property (@(posedge sys_clk) disable iff (!resetn)
        (cycle_active && !cycle_done && cnt_q == simb_pkg::BUS_TIMEOUT_CNT - 8'h01 && !fired_q)
        |=> pulse_q) else $error("bus timer did not fire at limit");
endmodule : simb_bus_timer
`default_nettype wire

// >>> simb_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module simb_cpu_model (
    // clock
    input wire logic sys_clk,
    // acknowledge cycle
    output logic iack_cycle,
    output logic [2:0] iack_level,
    // bus cycle
    output logic cycle_active,
    output logic cycle_done
);
    initial begin
        iack_cycle = 1'b0;
        iack_level = 3'h0;
        cycle_active = 1'b0;
        cycle_done = 1'b0;
    end

    // one acknowledge cycle; the level lines show garbage once released
    task automatic ack(input logic [2:0] lvl);
        @(posedge sys_clk);
        iack_cycle <= 1'b1;
        iack_level <= lvl;
        @(posedge sys_clk);
        iack_cycle <= 1'b0;
        iack_level <= ~lvl;
        #1;
    endtask : ack

    task automatic bus_open();
        @(posedge sys_clk);
        cycle_active <= 1'b1;
    endtask : bus_open

    // terminate by a done pulse, or abandon by dropping the cycle
    task automatic bus_close(input logic term);
        @(posedge sys_clk);
        if (term) begin
            cycle_done <= 1'b1;
        end else begin
            cycle_active <= 1'b0;
        end
        @(posedge sys_clk);
        cycle_done <= 1'b0;
        cycle_active <= 1'b0;
        #1;
    endtask : bus_close
endmodule : simb_cpu_model
`default_nettype wire

// >>> simb_pkg.sv
package simb_pkg;
    // register indices on the plain register port
    localparam logic [3:0] ADDR_SYS_MASK = 4'h0;
    localparam logic [3:0] ADDR_EXP_MASK = 4'h1;
    localparam logic [3:0] ADDR_RAW_STATUS = 4'h2;
    localparam logic [3:0] ADDR_SOFT_IRQ = 4'h3;
    localparam logic [3:0] ADDR_EVT_STATUS = 4'h4;
    localparam logic [3:0] ADDR_EVT_MASK = 4'h5;
    localparam logic [3:0] ADDR_BUS_STATUS = 4'h6;
    // reset values
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [2:0] EVT_RESET = 3'h0;
    // event status bit positions
    localparam int EVT_BUS_ERR = 0;
    localparam int EVT_POWER_FAIL = 1;
    localparam int EVT_SOFT = 2;
    // fixed levels
    localparam logic [2:0] LVL_SOFT = 3'h1;
    localparam logic [2:0] LVL_INTERNAL = 3'h3;
    localparam logic [2:0] LVL_VEC_A = 3'h5;
    localparam logic [2:0] LVL_VEC_B = 3'h6;
    localparam logic [2:0] LVL_TOP = 3'h7;
    // bus watchdog: 16 us at 10 MHz
    localparam int CLK_PERIOD_NS = 100;
    localparam int BUS_TIMEOUT_NS = 16000;
    localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam logic [7:0] BUS_TIMEOUT_CNT = 8'(BUS_TIMEOUT_CYC);
    localparam logic [7:0] CNT_ZERO = 8'h00;
endpackage : simb_pkg

// >>> simb_top.sv
// Overview of operation
// - two writable masks gate all requests
// - masked requests never reach processor
// - reset clears both masks to zero
// - readable status latches seven request levels
// - status shows raw lines before masking
// - register write raises level 1 autovector
// - only levels 5,6 acknowledge externally
// - internal levels 1,3 always autovectored
// - power-fail line raises level 7
// - level 7 only power-fail or card
// - bus error after 16 us unterminated
// - peripheral unit interrupts pass the masks
`timescale 1ns/1ps
`default_nettype none
module simb_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // request sources, board and card bit n is level n (bit 0 unused, board bit 7 ignored)
    input wire logic [7:0] board_irq,
    input wire logic [1:0] periph_unit_irq,
    input wire logic [7:0] card_irq,
    input wire logic power_fail,
    // processor interrupt interface
    output logic [2:0] cpu_ipl,
    input wire logic iack_cycle,
    input wire logic [2:0] iack_level,
    output logic iack5_out,
    output logic iack6_out,
    output logic autovector,
    // processor bus cycle
    input wire logic cycle_active,
    input wire logic cycle_done,
    output logic bus_error,
    // event interrupt
    output logic evt_irq
);
    logic [7:0] sys_mask_q;
    logic [7:0] exp_mask_q;
    logic [7:0] raw_q;
    logic [7:0] raw_d;
    logic [7:0] sys_req;
    logic [7:0] gated;
    logic soft_q;
    logic [2:0] ipl_d;
    logic [2:0] ipl_q;
    logic [7:0] rdata_q;
    logic [2:0] evt_q;
    logic [2:0] evt_mask_q;
    logic [2:0] evt_set;
    logic evt_irq_q;
    logic buserr_q;
    logic iack5_q;
    logic iack6_q;
    logic autovec_q;
    logic pf_q;
    logic tmo_pulse;
    logic [7:0] tmo_count;

    // main-board requests: peripheral units sit on levels 6 and 3 inputs,
    // software interrupt on level 1; level 7 only from power fail or cards
    always_comb begin
        sys_req = board_irq;
        sys_req[0] = 1'b0;
        sys_req[simb_pkg::LVL_TOP] = power_fail;
        sys_req[simb_pkg::LVL_VEC_B] = board_irq[simb_pkg::LVL_VEC_B] | periph_unit_irq[0];
        sys_req[simb_pkg::LVL_INTERNAL] = board_irq[simb_pkg::LVL_INTERNAL] | periph_unit_irq[1];
        sys_req[simb_pkg::LVL_SOFT] = board_irq[simb_pkg::LVL_SOFT] | soft_q;
    end

    // raw state of each level from any source, before masking
    always_comb begin
        raw_d = sys_req | card_irq;
        raw_d[0] = 1'b0;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            raw_q <= simb_pkg::MASK_RESET;
        end else begin
            raw_q <= raw_d;
        end
    end

    // per-level gating through both masks
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_gate
            assign gated[g] = (sys_req[g] & sys_mask_q[g]) | (card_irq[g] & exp_mask_q[g]);
        end
    endgenerate

    // priority encoder, level 7 highest
    always_comb begin
        ipl_d = 3'h0;
        for (int i = 1; i < 8; i++) begin
            if (gated[i]) begin
                ipl_d = 3'(i);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ipl_q <= 3'h0;
        end else begin
            ipl_q <= ipl_d;
        end
    end

    // mask registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sys_mask_q <= simb_pkg::MASK_RESET;
            exp_mask_q <= simb_pkg::MASK_RESET;
        end else if (reg_wr && reg_addr == simb_pkg::ADDR_SYS_MASK) begin
            sys_mask_q <= reg_wdata;
        end else if (reg_wr && reg_addr == simb_pkg::ADDR_EXP_MASK) begin
            exp_mask_q <= reg_wdata;
        end
    end

    // software interrupt: set by write, dropped when its autovector ack comes
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            soft_q <= 1'b0;
        end else if (reg_wr && reg_addr == simb_pkg::ADDR_SOFT_IRQ) begin
            soft_q <= 1'b1;
        end else if (iack_cycle && iack_level == simb_pkg::LVL_SOFT) begin
            soft_q <= 1'b0;
        end
    end

    // acknowledge routing: external pins for 5 and 6 only, rest autovectored
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            iack5_q <= 1'b0;
            iack6_q <= 1'b0;
            autovec_q <= 1'b0;
        end else begin
            iack5_q <= iack_cycle && iack_level == simb_pkg::LVL_VEC_A;
            iack6_q <= iack_cycle && iack_level == simb_pkg::LVL_VEC_B;
            autovec_q <= iack_cycle && iack_level != simb_pkg::LVL_VEC_A
                && iack_level != simb_pkg::LVL_VEC_B;
        end
    end

    simb_bus_timer u_timer (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .cycle_active(cycle_active),
        .cycle_done(cycle_done),
        .timeout_pulse(tmo_pulse),
        .count(tmo_count)
    );

    // bus error held until the cycle ends
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            buserr_q <= 1'b0;
        end else if (!cycle_active || cycle_done) begin
            buserr_q <= 1'b0;
        end else if (tmo_pulse) begin
            buserr_q <= 1'b1;
        end
    end

    // sticky events, set wins over write-one-to-clear
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pf_q <= 1'b0;
        end else begin
            pf_q <= power_fail;
        end
    end

    always_comb begin
        evt_set = simb_pkg::EVT_RESET;
        evt_set[simb_pkg::EVT_BUS_ERR] = tmo_pulse;
        evt_set[simb_pkg::EVT_POWER_FAIL] = power_fail & ~pf_q;
        evt_set[simb_pkg::EVT_SOFT] = reg_wr && reg_addr == simb_pkg::ADDR_SOFT_IRQ;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            evt_q <= simb_pkg::EVT_RESET;
        end else if (reg_wr && reg_addr == simb_pkg::ADDR_EVT_STATUS) begin
            evt_q <= (evt_q & ~reg_wdata[2:0]) | evt_set;
        end else begin
            evt_q <= evt_q | evt_set;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            evt_mask_q <= simb_pkg::EVT_RESET;
        end else if (reg_wr && reg_addr == simb_pkg::ADDR_EVT_MASK) begin
            evt_mask_q <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            evt_irq_q <= 1'b0;
        end else begin
            evt_irq_q <= |(evt_q & evt_mask_q);
        end
    end

    // read data, valid the cycle after the strobe only
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else if (!reg_rd) begin
            rdata_q <= 8'h00;
        end else if (reg_addr == simb_pkg::ADDR_SYS_MASK) begin
            rdata_q <= sys_mask_q;
        end else if (reg_addr == simb_pkg::ADDR_EXP_MASK) begin
            rdata_q <= exp_mask_q;
        end else if (reg_addr == simb_pkg::ADDR_RAW_STATUS) begin
            rdata_q <= raw_q;
        end else if (reg_addr == simb_pkg::ADDR_EVT_STATUS) begin
            rdata_q <= {5'h00, evt_q};
        end else if (reg_addr == simb_pkg::ADDR_EVT_MASK) begin
            rdata_q <= {5'h00, evt_mask_q};
        end else if (reg_addr == simb_pkg::ADDR_BUS_STATUS) begin
            rdata_q <= tmo_count;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata = rdata_q;
    assign cpu_ipl = ipl_q;
    assign iack5_out = iack5_q;
    assign iack6_out = iack6_q;
    assign autovector = autovec_q;
    assign bus_error = buserr_q;
    assign evt_irq = evt_irq_q;

    sequence s_soft_write;
        reg_wr && reg_addr == simb_pkg::ADDR_SOFT_IRQ;
    endsequence

    sequence s_soft_ack;
        iack_cycle && iack_level == simb_pkg::LVL_SOFT && !(reg_wr && reg_addr == simb_pkg::ADDR_SOFT_IRQ);
    endsequence

    sequence s_power_rise;
        power_fail && !pf_q;
    endsequence

    sequence s_hung_cycle;
        tmo_pulse && cycle_active && !cycle_done;
    endsequence

    // register port and masks
    a_mask_blocks: assert property (@(posedge sys_clk) disable iff (!resetn)
        (sys_mask_q == 8'h00 && exp_mask_q == 8'h00) |=> cpu_ipl == 3'h0)
        else $error("level shown while all masked");
    a_top_masked: assert property (@(posedge sys_clk) disable iff (!resetn)
        ((!power_fail || !sys_mask_q[7]) && (!card_irq[7] || !exp_mask_q[7])) |=> cpu_ipl != 3'h7)
        else $error("masked level 7 shown");
    a_reset_masks: assert property (@(posedge sys_clk)
        !resetn |=> (sys_mask_q == 8'h00 && exp_mask_q == 8'h00))
        else $error("masks not cleared by reset");
    a_reset_level: assert property (@(posedge sys_clk)
        !resetn |=> cpu_ipl == 3'h0)
        else $error("level shown after reset");
    a_mask_write: assert property (@(posedge sys_clk) disable iff (!resetn)
        (reg_wr && reg_addr == simb_pkg::ADDR_EXP_MASK) |=> exp_mask_q == $past(reg_wdata))
        else $error("expansion mask not written");
    a_mask_read: assert property (@(posedge sys_clk) disable iff (!resetn)
        (reg_rd && reg_addr == simb_pkg::ADDR_SYS_MASK) |=> reg_rdata == $past(sys_mask_q))
        else $error("system mask not readable");
    // status latch
    a_raw_status: assert property (@(posedge sys_clk) disable iff (!resetn)
        1'b1 |=> (raw_q[7] == $past(power_fail | card_irq[7]) && raw_q[5] == $past(board_irq[5] | card_irq[5])
            && !raw_q[0])) else $error("raw status not latched");
    a_raw_unmasked: assert property (@(posedge sys_clk) disable iff (!resetn)
        card_irq[4] |=> raw_q[4])
        else $error("raw status depends on mask");
    a_soft_raw: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_soft_write |=> ##1 raw_q[1])
        else $error("soft request missing from raw status");
    a_raw_read: assert property (@(posedge sys_clk) disable iff (!resetn)
        (reg_rd && reg_addr == simb_pkg::ADDR_RAW_STATUS) |=> reg_rdata == $past(raw_q))
        else $error("raw status not readable");
    // software interrupt and acknowledge routing
    a_soft_level: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_soft_write ##1 (sys_mask_q[1] && !iack_cycle) |=> cpu_ipl >= 3'h1)
        else $error("software interrupt not raised");
    a_soft_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_soft_ack |=> !soft_q)
        else $error("software interrupt not dropped by ack");
    a_vector_pins: assert property (@(posedge sys_clk) disable iff (!resetn)
        (iack_cycle && iack_level == 3'h5) |=> (iack5_out && !autovector && !iack6_out))
        else $error("level 5 ack not external");
    a_vector_six: assert property (@(posedge sys_clk) disable iff (!resetn)
        (iack_cycle && iack_level == simb_pkg::LVL_VEC_B) |=> (iack6_out && !autovector && !iack5_out))
        else $error("level 6 ack not external");
    a_ack_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
        !iack_cycle |=> !(iack5_out || iack6_out || autovector))
        else $error("ack output without ack cycle");
    a_auto_levels: assert property (@(posedge sys_clk) disable iff (!resetn)
        (iack_cycle && (iack_level == 3'h1 || iack_level == 3'h3)) |=> (autovector && !iack5_out))
        else $error("internal level not autovectored");
    // level 7 sources
    a_power_fail: assert property (@(posedge sys_clk) disable iff (!resetn)
        (power_fail && sys_mask_q[7]) |=> cpu_ipl == 3'h7)
        else $error("power fail not level 7");
    a_pf_event: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_power_rise |=> evt_q[simb_pkg::EVT_POWER_FAIL])
        else $error("power fail event lost");
    a_top_source: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!power_fail && !card_irq[7]) |=> !raw_q[7]) else $error("bad level 7 source");
    a_card_top: assert property (@(posedge sys_clk) disable iff (!resetn)
        (card_irq[7] && exp_mask_q[7]) |=> cpu_ipl == 3'h7)
        else $error("card level 7 not shown");
    // bus timer
    a_bus_error: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_hung_cycle |=> bus_error) else $error("bus error not raised");
    a_buserr_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!cycle_active || cycle_done) |=> !bus_error) else $error("bus error outlives its cycle");
    a_buserr_event: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_hung_cycle |=> evt_q[simb_pkg::EVT_BUS_ERR]) else $error("bus error event lost");
    // peripheral units and priority
    a_periph_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
        (periph_unit_irq[0] && sys_mask_q[6] && !power_fail && !(card_irq[7] && exp_mask_q[7]))
        |=> cpu_ipl == 3'h6) else $error("peripheral unit not passed");
    a_periph_three: assert property (@(posedge sys_clk) disable iff (!resetn)
        (periph_unit_irq[1] && sys_mask_q[3] && !(|gated[7:4])) |=> cpu_ipl == 3'h3)
        else $error("peripheral unit level 3 not passed");
    a_raw_periph: assert property (@(posedge sys_clk) disable iff (!resetn)
        periph_unit_irq[1] |=> raw_q[3])
        else $error("peripheral unit missing from status");
    a_top_priority: assert property (@(posedge sys_clk) disable iff (!resetn)
        (gated[7]) |=> cpu_ipl == 3'h7) else $error("level 7 not highest");
endmodule : simb_top
`default_nettype wire

// >>> tb_system_interrupt_mask_bus_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_system_interrupt_mask_bus_timer;
    typedef struct packed {
        logic [7:0] brd;
        logic [1:0] per;
        logic [7:0] crd;
        logic pf;
        logic [7:0] sm;
        logic [7:0] em;
        logic [2:0] ipl;
        logic [7:0] raw;
    } simb_row_t;
    localparam int TIMEOUT_CYC = 3000;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] board_irq = 8'h00;
    logic [7:0] card_irq = 8'h00;
    logic [1:0] periph_unit_irq = 2'h0;
    logic power_fail = 1'b0;
    logic [7:0] reg_rdata;
    logic [2:0] cpu_ipl;
    logic [2:0] iack_level;
    logic iack_cycle, iack5_out, iack6_out, autovector, cycle_active, cycle_done, bus_error, evt_irq;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    simb_row_t rows [10] = '{
        '{8'h02, 2'h0, 8'h00, 1'b0, 8'h00, 8'h00, 3'h0, 8'h02},
        '{8'h02, 2'h0, 8'h00, 1'b0, 8'h02, 8'h00, 3'h1, 8'h02},
        '{8'hFE, 2'h0, 8'h00, 1'b0, 8'hFF, 8'h00, 3'h6, 8'h7E},
        '{8'h00, 2'h1, 8'h00, 1'b0, 8'h40, 8'h00, 3'h6, 8'h40},
        '{8'h00, 2'h3, 8'h00, 1'b0, 8'h08, 8'h00, 3'h3, 8'h48},
        '{8'h00, 2'h0, 8'h80, 1'b0, 8'h00, 8'h80, 3'h7, 8'h80},
        '{8'h00, 2'h0, 8'h80, 1'b0, 8'hFF, 8'h00, 3'h0, 8'h80},
        '{8'h00, 2'h0, 8'h00, 1'b1, 8'h80, 8'h00, 3'h7, 8'h80},
        '{8'h10, 2'h0, 8'h24, 1'b0, 8'h10, 8'h04, 3'h4, 8'h34},
        '{8'h01, 2'h0, 8'h00, 1'b0, 8'hFF, 8'h00, 3'h0, 8'h00}
    };

    always #50 sys_clk = ~sys_clk;

    simb_top dut_u (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .board_irq(board_irq),
        .periph_unit_irq(periph_unit_irq), .card_irq(card_irq), .power_fail(power_fail),
        .cpu_ipl(cpu_ipl), .iack_cycle(iack_cycle), .iack_level(iack_level), .iack5_out(iack5_out),
        .iack6_out(iack6_out), .autovector(autovector), .cycle_active(cycle_active),
        .cycle_done(cycle_done), .bus_error(bus_error), .evt_irq(evt_irq));

    simb_cpu_model cpu_u (.sys_clk(sys_clk), .iack_cycle(iack_cycle), .iack_level(iack_level),
        .cycle_active(cycle_active), .cycle_done(cycle_done));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rdc

    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT_CYC) begin
            fails = fails + 1;
            $display("MISMATCH at %0t: run did not finish in time", $time);
            conclude();
        end
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk({2'h0, bus_error, evt_irq, autovector, iack5_out, iack6_out, |cpu_ipl}, 8'h00);
        rdc(simb_pkg::ADDR_SYS_MASK, simb_pkg::MASK_RESET);
        rdc(simb_pkg::ADDR_EXP_MASK, simb_pkg::MASK_RESET);
        for (int i = 0; i < 10; i++) begin
            @(posedge sys_clk);
            board_irq <= rows[i].brd;
            periph_unit_irq <= rows[i].per;
            card_irq <= rows[i].crd;
            power_fail <= rows[i].pf;
            wr(simb_pkg::ADDR_SYS_MASK, rows[i].sm);
            wr(simb_pkg::ADDR_EXP_MASK, rows[i].em);
            settle();
            chk({5'h00, cpu_ipl}, {5'h00, rows[i].ipl});
            rdc(simb_pkg::ADDR_RAW_STATUS, rows[i].raw);
        end
        rdc(simb_pkg::ADDR_SYS_MASK, 8'hFF);
        @(posedge sys_clk);
        board_irq <= 8'h00;
        #1;
        chk(reg_rdata, 8'h00);
        // power-fail edge left a sticky event; unmask it, then clear it
        rdc(simb_pkg::ADDR_EVT_STATUS, 8'h02);
        chk({7'h00, evt_irq}, 8'h00);
        wr(simb_pkg::ADDR_EVT_MASK, 8'h02);
        settle();
        chk({7'h00, evt_irq}, 8'h01);
        wr(simb_pkg::ADDR_EVT_STATUS, 8'h02);
        settle();
        chk({7'h00, evt_irq}, 8'h00);
        // software interrupt at level 1, cleared by its acknowledge
        wr(simb_pkg::ADDR_SYS_MASK, 8'h02);
        wr(simb_pkg::ADDR_SOFT_IRQ, 8'h00);
        settle();
        chk({5'h00, cpu_ipl}, {5'h00, simb_pkg::LVL_SOFT});
        rdc(simb_pkg::ADDR_SOFT_IRQ, 8'h00);
        rdc(simb_pkg::ADDR_EVT_STATUS, 8'h04);
        cpu_u.ack(simb_pkg::LVL_SOFT);
        chk({5'h00, iack5_out, iack6_out, autovector}, 8'h01);
        settle();
        chk({5'h00, cpu_ipl}, 8'h00);
        for (int l = 1; l < 8; l++) begin
            cpu_u.ack(3'(l));
            chk({5'h00, iack5_out, iack6_out, autovector}, {5'h00, l == 5, l == 6, l != 5 && l != 6});
        end
        // unmapped index: write ignored, reads zero
        wr(4'hF, 8'hFF);
        rdc(4'hF, 8'h00);
        rdc(simb_pkg::ADDR_SYS_MASK, 8'h02);
        // prompt cycle, then one left hanging
        cpu_u.bus_open();
        repeat (20) @(posedge sys_clk);
        cpu_u.bus_close(1'b1);
        chk({7'h00, bus_error}, 8'h00);
        cpu_u.bus_open();
        repeat (158) @(posedge sys_clk);
        #1;
        chk({7'h00, bus_error}, 8'h00);
        repeat (4) @(posedge sys_clk);
        #1;
        chk({7'h00, bus_error}, 8'h01);
        rdc(simb_pkg::ADDR_EVT_STATUS, 8'h05);
        rdc(simb_pkg::ADDR_BUS_STATUS, simb_pkg::BUS_TIMEOUT_CNT - 8'h01);
        cpu_u.bus_close(1'b0);
        chk({7'h00, bus_error}, 8'h00);
        // reset in mid-run must clear the system mask written so far
        @(posedge sys_clk);
        board_irq <= 8'h02;
        repeat (3) @(posedge sys_clk);
        #1;
        chk({5'h00, cpu_ipl}, {5'h00, simb_pkg::LVL_SOFT});
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk({5'h00, cpu_ipl}, 8'h00);
        rdc(simb_pkg::ADDR_SYS_MASK, simb_pkg::MASK_RESET);
        conclude();
    end
endmodule : tb_system_interrupt_mask_bus_timer
`default_nettype wire
